// ---- pwtd_pkg.sv ----
// pwtd_pkg: constants and state type for the pulse-width temperature decoder.
// Assumes a single 20 MHz system clock; every slower rate comes from enable pulses.
package pwtd_pkg;
  localparam int          CLK_HZ      = 20_000_000;            // system clock rate
  localparam int          TICK_HZ     = 1_000_000;             // reference tick rate
  localparam int          TICK_DIV    = CLK_HZ / TICK_HZ;      // clocks per tick
  localparam logic [7:0]  PRESCALE_1M = 8'(TICK_DIV - 1);      // n-1 setting for 1 MHz
  localparam int          STAGE_W     = 8;                     // width of one counter stage
  localparam int          N_STAGES    = 2;                     // cascaded stages
  localparam int          CNT_W       = STAGE_W * N_STAGES;    // phase counter width
  localparam logic [15:0] CNT_FULL    = 16'hFFFF;              // down-count preload
  localparam logic [15:0] CNT_ZERO    = 16'h0000;              // up-count restart value
  localparam int          ERR_BIT     = CNT_W - 1;             // msb means phase too long
  localparam logic [31:0] RATIO_SCALE = 32'h0000_0640;         // 400 * 4 for two frac bits
  localparam logic [17:0] TEMP_OFFSET = 18'h003AC;             // 235 * 4
  localparam logic [15:0] Q_SAT       = 16'hFFFF;              // quotient saturation
  localparam int          DIV_STEPS   = 32;                    // divider iterations
  typedef enum logic [1:0] {PWTD_IDLE, PWTD_CAPTURE, PWTD_CLEAR} pwtd_state_type;
endpackage

// ---- pwtd_decoder.sv ----
// pwtd_decoder: measures high and low phases of a duty-cycle sensor pin and
// turns the pair into a 14.2 fixed-point temperature.
// Assumes flag_input_pin is asynchronous; all other inputs synchronous to clk_sys.
// Assumes read_ack is a one-cycle pulse and count_down changes between phases only.
`timescale 1ns/1ps
`default_nettype none
module pwtd_decoder (
  input  wire logic        clk_sys,          // 20 MHz system clock
  input  wire logic        resetn,           // async reset, active low
  input  wire logic        flag_input_pin,   // sensor output, asynchronous
  input  wire logic [7:0]  prescale,         // n-1, tick = clk_sys / n
  input  wire logic        count_down,       // 1: preloaded down-counter mode
  input  wire logic        read_ack,         // pulse: results have been read
  output logic [15:0]      high_phase_time,  // latest high phase count
  output logic [15:0]      low_phase_time,   // latest low phase count
  output logic [15:0]      last_phase_time,  // most recent capture, either phase
  output logic             last_phase_level, // 1: last capture was a high phase
  output logic             pair_ready,       // sticky, complete pair latched
  output logic             link_error,       // sticky, phase overran half scale
  output logic [15:0]      temperature,      // signed degrees, 14.2
  output logic             temp_valid,       // sticky, temperature updated
  output logic             busy              // divider working
);
  import pwtd_pkg::*;
  // counter widths and counts below come from the package; prescaler and divider widths are written out

  // synchroniser and edge detect
  logic sync_a;         // first stage, read only by sync_b
  logic sync_b;         // second stage
  logic level_q;        // delayed copy for edge detect
  logic [7:0] pre_cnt;  // prescaler count
  wire  [CNT_W-1:0] cnt;           // phase counter, one slice per stage
  wire  [N_STAGES-1:0] stage_carry; // carry into each stage
  pwtd_state_type state;
  pwtd_state_type next_state;
  // divider
  logic [31:0] div_num;    // dividend shifting out
  logic [32:0] div_rem;    // partial remainder
  logic [31:0] div_quo;    // quotient
  logic [15:0] div_den;    // divisor, low time
  logic [5:0]  div_steps;  // remaining iterations

  // pin synchroniser; nothing but sync_b reads the first stage
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sync_a  <= 1'b0;
      sync_b  <= 1'b0;
      level_q <= 1'b0;
    end else begin
      sync_a  <= flag_input_pin;
      sync_b  <= sync_a;
      level_q <= sync_b;
    end
  end

  // xor of the synchronised level and its delayed copy: both edges, one cycle each
  wire pin_edge  = sync_b ^ level_q;
  // tick enable; divide by prescale+1
  // >= rather than == so a smaller prescale takes hold at once, not after a wrap
  wire tick      = (pre_cnt >= prescale);
  // one strobe per edge: capture for one cycle, then clear for one
  wire capture   = (state == PWTD_CAPTURE);
  wire clear_cnt = (state == PWTD_CLEAR);
  // counting value seen as elapsed time in either mode
  wire [CNT_W-1:0] elapsed = count_down ? (CNT_FULL - cnt) : cnt;
  // the counter parks at its end (full scale up, zero down) instead of wrapping, so a dead link stays flagged
  wire at_limit  = count_down ? (cnt == CNT_ZERO) : (cnt == CNT_FULL);
  // frozen outside idle, so no tick lands in the capture or the clear cycle
  wire run       = tick && (state == PWTD_IDLE) && !at_limit;
  // level after the edge; low now means a high phase just ended
  wire ended_high = capture && !level_q;
  wire ended_low  = capture && level_q;

  // prescaler
  // free-running; it keeps going through capture and clear
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pre_cnt <= 8'h00;
    end else if (tick) begin
      pre_cnt <= 8'h00;
    end else begin
      pre_cnt <= pre_cnt + 8'h01;
    end
  end

  // two cascaded 8-bit stages; stage k steps when all lower stages wrap
  genvar k;
  generate
    for (k = 0; k < N_STAGES; k++) begin : g_stage
      // down mode borrows when the lower stage sits at zero, up mode carries at all ones
      wire [STAGE_W-1:0] wrap_val = count_down ? {STAGE_W{1'b0}} : {STAGE_W{1'b1}};
      logic [STAGE_W-1:0] stage_q; // this stage's count
      // each stage owns its flop; the slices are stitched into cnt here
      assign cnt[k*STAGE_W +: STAGE_W] = stage_q;
      if (k == 0) begin : g_first
        assign stage_carry[k] = run;
      end else begin : g_next
        assign stage_carry[k] = stage_carry[k-1] && (cnt[(k-1)*STAGE_W +: STAGE_W] == wrap_val);
      end
      // stage register; the clear wins over a carry in the same cycle
      always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
          stage_q <= {STAGE_W{1'b0}};
        end else if (clear_cnt) begin
          // restart: zero up, full scale down
          stage_q <= count_down ? CNT_FULL[k*STAGE_W +: STAGE_W]
                                : CNT_ZERO[k*STAGE_W +: STAGE_W];
        end else if (stage_carry[k]) begin
          stage_q <= count_down ? stage_q - {{(STAGE_W-1){1'b0}}, 1'b1}
                                : stage_q + {{(STAGE_W-1){1'b0}}, 1'b1};
        end
      end
    end
  endgenerate

  // capture then clear; edges inside these two cycles are lost, harmless for ms phases
  // the capture always comes a cycle before the clear
  always_comb begin
    case (state)
      PWTD_IDLE:    next_state = pin_edge ? PWTD_CAPTURE : PWTD_IDLE;
      PWTD_CAPTURE: next_state = PWTD_CLEAR;
      PWTD_CLEAR:   next_state = PWTD_IDLE;
      default:      next_state = PWTD_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state <= PWTD_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // holding registers
  // only the register of the ended phase moves; the other keeps its last value
  // the single-register view carries the level so a reader can tell the phases apart
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      high_phase_time  <= 16'h0000;
      low_phase_time   <= 16'h0000;
      last_phase_time  <= 16'h0000;
      last_phase_level <= 1'b0;
    end else if (capture) begin
      last_phase_time  <= elapsed;
      last_phase_level <= !level_q;
      if (ended_high) begin
        high_phase_time <= elapsed;
      end else begin
        low_phase_time  <= elapsed;
      end
    end
  end

  // sticky flags; setting wins over read_ack
  // a read in the set cycle is dropped on purpose, so no event goes unseen
  // link error watches the msb: no valid phase ever reaches half scale
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pair_ready <= 1'b0;
      link_error <= 1'b0;
    end else begin
      pair_ready <= ended_low || (pair_ready && !read_ack);
      link_error <= elapsed[ERR_BIT] || (link_error && !read_ack);
    end
  end

  // divider: quotient = 1600 * high / low, one bit per clock
  wire        div_start = ended_low && (elapsed != CNT_ZERO);
  wire [32:0] div_try   = {div_rem[31:0], div_num[31]};
  wire        div_fits  = (div_try >= {17'h00000, div_den});
  // quotient after the step in progress; the last step's bit is not in div_quo yet
  wire [31:0] div_quo_next = {div_quo[30:0], div_fits};
  // final step this cycle, unless a new low capture restarts the divider
  wire        div_last  = (div_steps == 6'h01) && !div_start;
  // saturation keeps a very short low phase from wrapping the 16-bit quotient; the temperature can still wrap
  wire [15:0] q_sat     = (div_quo_next > {16'h0000, Q_SAT}) ? Q_SAT : div_quo_next[15:0];
  // 235*4 - quotient, both in quarters of a degree
  wire [17:0] temp_calc = TEMP_OFFSET - {2'b00, q_sat};

  // restoring division, one quotient bit per clock, 32 clocks per result
  // a new low capture restarts it even mid-run; only the newest pair matters
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      div_num   <= 32'h0000_0000;
      div_rem   <= 33'h0_0000_0000;
      div_quo   <= 32'h0000_0000;
      div_den   <= 16'h0000;
      div_steps <= 6'h00;
    end else if (div_start) begin
      // ratio only: tick rate cancels out
      div_num   <= 32'(high_phase_time) * RATIO_SCALE;
      div_rem   <= 33'h0_0000_0000;
      div_quo   <= 32'h0000_0000;
      div_den   <= elapsed;
      div_steps <= 6'(DIV_STEPS);
    end else if (busy) begin
      div_num   <= {div_num[30:0], 1'b0};
      div_rem   <= div_fits ? (div_try - {17'h00000, div_den}) : div_try;
      div_quo   <= div_quo_next;
      div_steps <= div_steps - 6'h01;
    end
  end

  // busy straight from the step counter, no extra flop
  assign busy = (div_steps != 6'h00);

  // result register
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      temperature <= 16'h0000;
      temp_valid  <= 1'b0;
    end else begin
      // latch on the final step, with the bit that step produces
      if (div_last) begin
        temperature <= 16'(temp_calc);
      end
      temp_valid <= div_last || (temp_valid && !read_ack);
    end
  end

endmodule // pwtd_decoder
`default_nettype wire

// ---- pwtd_checker.sv ----
// pwtd_checker: port timing checks for pwtd_decoder.
// Assumes sensor phases stay at least 4 clocks apart and read_ack avoids capture cycles.
`timescale 1ns/1ps
`default_nettype none
module pwtd_checker (
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic        flag_input_pin,
  input wire logic        read_ack,
  input wire logic [15:0] high_phase_time,
  input wire logic [15:0] low_phase_time,
  input wire logic [15:0] last_phase_time,
  input wire logic        last_phase_level,
  input wire logic        pair_ready,
  input wire logic        link_error,
  input wire logic        temp_valid,
  input wire logic        busy
);
  logic s1, s2, s3; // mirror of the two-stage pin synchroniser plus level
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) {s1, s2, s3} <= 3'h0;
    else {s1, s2, s3} <= {flag_input_pin, s1, s2};
  end
  wire logic rise = s2 & ~s3; // low phase just ended
  wire logic fall = ~s2 & s3; // high phase just ended
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_high_capture: assert property (fall |-> ##2 last_phase_level && high_phase_time == last_phase_time)
    else $error("high capture missed");
  a_low_capture: assert property (rise |-> ##2 !last_phase_level && low_phase_time == last_phase_time)
    else $error("low capture missed");
  a_pair_set: assert property (rise |-> ##2 pair_ready)
    else $error("pair flag not set");
  a_pair_clear: assert property (read_ack && !$past(rise) |=> !pair_ready)
    else $error("pair flag not cleared");
  a_hold_regs: assert property ($changed(high_phase_time) || $changed(low_phase_time) |-> $past(rise || fall, 2))
    else $error("phase register changed without edge");
  a_busy_bound: assert property ($rose(busy) |-> ##[1:40] !busy)
    else $error("divider too slow");
  a_temp_done: assert property ($fell(busy) |-> ##[0:1] temp_valid)
    else $error("temperature not flagged");
  a_err_sticky: assert property (link_error && !read_ack |=> link_error)
    else $error("error flag dropped");
endmodule // pwtd_checker
bind pwtd_decoder pwtd_checker u_pwtd_checker (.clk_sys(clk_sys), .resetn(resetn),
  .flag_input_pin(flag_input_pin), .read_ack(read_ack), .high_phase_time(high_phase_time),
  .low_phase_time(low_phase_time), .last_phase_time(last_phase_time), .last_phase_level(last_phase_level),
  .pair_ready(pair_ready), .link_error(link_error), .temp_valid(temp_valid), .busy(busy));
`default_nettype wire

// ---- pwtd_sensor_model.sv ----
// pwtd_sensor_model: push-pull duty-cycle sensor output.
// Assumes calls come at falling clock edges; pin idles low.
`timescale 1ns/1ps
`default_nettype none
module pwtd_sensor_model (
  input wire logic clk_sys,
  output logic     pin
);
  initial pin = 1'b0; // low until the first period
  // one period; the next call's rise ends the low phase
  task automatic send(input int hi, input int lo);
    pin = 1'b1;
    repeat (hi) @(negedge clk_sys);
    pin = 1'b0;
    repeat (lo) @(negedge clk_sys);
  endtask
endmodule // pwtd_sensor_model
`default_nettype wire

// ---- tb.sv ----
// tb: self-checking bench for pwtd_decoder.
// Assumes the checker binds itself; counts carry a few ticks of slack for sync and clear.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import pwtd_pkg::*;
  logic        clk_sys = 1'b0, resetn = 1'b0, read_ack = 1'b0, count_down = 1'b0, pin;
  logic [7:0]  prescale = PRESCALE_1M;
  logic [15:0] high_phase_time, low_phase_time, last_phase_time, temperature;
  logic        pair_ready, link_error, temp_valid, last_phase_level, busy;
  int          n_mismatch = 0, compares = 0;
  // prescale, down mode, high ticks, low ticks
  int rows [5][4] = '{'{19,0,60,100}, '{4,0,60,100}, '{0,1,300,500}, '{4,1,100,250}, '{0,0,50,50}};
  always #25 clk_sys = ~clk_sys;
  pwtd_sensor_model u_pwtd_sensor_model (.clk_sys(clk_sys), .pin(pin));
  pwtd_decoder u_pwtd_decoder (.clk_sys(clk_sys), .resetn(resetn), .flag_input_pin(pin), .prescale(prescale),
    .count_down(count_down), .read_ack(read_ack), .high_phase_time(high_phase_time),
    .low_phase_time(low_phase_time), .last_phase_time(last_phase_time), .last_phase_level(last_phase_level),
    .pair_ready(pair_ready), .link_error(link_error), .temperature(temperature), .temp_valid(temp_valid),
    .busy(busy));
  // range compare, signed view
  task automatic chk(input logic [31:0] got, input int lo, input int hi);
    compares++;
    if (^got === 1'bx || $signed(got) < lo || $signed(got) > hi) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  function automatic int tq(input int h, input int l);
    return 940 - (1600 * h) / l; // quarter degrees
  endfunction
  task automatic final_report;
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // hang guard, about 1.7 times the expected run of some 53k cycles
  initial begin
    #(90_000 * 50);
    n_mismatch++;
    final_report;
  end
  initial begin
    repeat (2) @(negedge clk_sys);
    resetn = 1'b1;
    chk({14'h0, high_phase_time, pair_ready, link_error}, 0, 0);
    $display("reset test done");
    // first period after a mode change is junk, so three periods per row
    foreach (rows[i]) begin
      prescale = 8'(rows[i][0]);
      count_down = rows[i][1][0];
      repeat (3) u_pwtd_sensor_model.send(rows[i][2] * (rows[i][0] + 1), rows[i][3] * (rows[i][0] + 1));
      chk({16'h0, high_phase_time}, rows[i][2] - 4, rows[i][2] + 1);
      chk({16'h0, low_phase_time}, rows[i][3] - 4, rows[i][3] + 1);
      chk({{16{temperature[15]}}, temperature}, tq(rows[i][2] + 1, rows[i][3] - 4), tq(rows[i][2] - 4, rows[i][3] + 1));
      chk({16'h0, last_phase_time}, rows[i][2] - 4, rows[i][2] + 1);
      chk({31'h0, last_phase_level}, 1, 1);
      chk({31'h0, temp_valid}, 1, 1);
      $display("row %0d done", i);
    end
    prescale = 8'h00;
    count_down = 1'b0;
    // mode changes leave junk counts that may set the flag; start from a clean flag
    read_ack = 1'b1;
    @(negedge clk_sys);
    read_ack = 1'b0;
    chk({31'h0, link_error}, 0, 0);
    u_pwtd_sensor_model.send(33000, 20); // phase past half scale
    u_pwtd_sensor_model.send(20, 40);
    chk({31'h0, link_error}, 1, 1);
    chk({16'h0, temperature}, 941, 941);
    read_ack = 1'b1;
    @(negedge clk_sys);
    read_ack = 1'b0;
    chk({30'h0, link_error, pair_ready}, 0, 0);
    $display("link error test done");
    // reset in mid-run: everything back to zero, then a period measures again
    resetn = 1'b0;
    @(negedge clk_sys);
    chk({high_phase_time, low_phase_time}, 0, 0);
    chk({12'h0, temperature, temp_valid, pair_ready, link_error, busy}, 0, 0);
    @(negedge clk_sys);
    resetn = 1'b1;
    u_pwtd_sensor_model.send(30, 30);
    chk({16'h0, high_phase_time}, 26, 31);
    $display("mid-run reset test done");
    final_report;
  end
endmodule // tb
`default_nettype wire
